// [hw/dbc_consts.svh]
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH

// ==========================================================================
// Register indices (byte address = index * 4)
`define DBC_IDX_W          10
`define DBC_IDX_A_CTL      10'h110
`define DBC_IDX_A_ADDR_H   10'h115
`define DBC_IDX_A_ADDR_M   10'h116
`define DBC_IDX_A_ADDR_L   10'h117
`define DBC_IDX_A_DATA0    10'h118
`define DBC_IDX_A_MASK0    10'h11C
`define DBC_IDX_B_CTL      10'h120
`define DBC_IDX_B_ADDR_H   10'h125
`define DBC_IDX_B_ADDR_M   10'h126
`define DBC_IDX_B_ADDR_L   10'h127
`define DBC_IDX_CONFIG     10'h140
`define DBC_IDX_STATUS     10'h141
`define DBC_BYTES_PER_WORD 4

// ==========================================================================
// Bus widths
`define DBC_AXI_AW         12
`define DBC_IDX_LSB        2
`define DBC_ADDR_W         24
`define DBC_DATA_W         32

// ==========================================================================
// Control byte fields
`define DBC_CTL_NDB        6
`define DBC_CTL_INSTRUCTION_SELECT       5
`define DBC_CTL_RW         3
`define DBC_CTL_RWE        2
`define DBC_CTL_EN         0
`define DBC_CTL_A_MASK     8'h6D
`define DBC_CTL_B_MASK     8'h2D

// ==========================================================================
// Config and status fields
`define DBC_CFG_RANGE      0
`define DBC_STS_ARMED      0
`define DBC_STS_PROF       1
`define DBC_STS_MATCH_A    2
`define DBC_STS_MATCH_B    3

// ==========================================================================
// Reset values
`define DBC_RST_CTL        8'h00
`define DBC_RST_ADDR       24'h000000
`define DBC_RST_DATA       32'h00000000
`define DBC_RST_MASK       32'h00000000
`define DBC_RST_CFG        1'b0

// ==========================================================================
// AXI responses
`define DBC_RESP_OKAY      2'h0
`define DBC_RESP_SLVERR    2'h2

`endif

// [hw/dbc_pkg.sv]
package dbc_pkg;

   // Core bus seen by the comparators
   typedef struct packed {
      logic        access_valid;
      logic        rw;
      logic [23:0] addr;
      logic [31:0] data;
      logic        fetch_valid;
      logic [23:0] pc;
   } dbc_core_bus_t;

   // Decoded comparator control
   typedef struct packed {
      logic data_mismatch_select;
      logic instruction_select;
      logic rw;
      logic direction_qualify_enable;
      logic en;
   } dbc_ctl_t;

endpackage

// [hw/dbc_match.sv]
`timescale 1ns/1ps
`include "dbc_consts.svh"

module dbc_match
   import dbc_pkg::*;
(
   input  wire dbc_ctl_t                  ctl,
   input  wire logic [`DBC_ADDR_W-1:0]    cmp_addr,
   input  wire logic [`DBC_DATA_W-1:0]    data_val,
   input  wire logic [`DBC_DATA_W-1:0]    data_mask,
   input  wire logic                      use_data,
   input  wire logic                      range_mode,
   input  wire logic [`DBC_ADDR_W-1:0]    range_hi,
   input  wire dbc_core_bus_t             bus,
   output logic                           hit
);

   logic                   sel_valid;
   logic [`DBC_ADDR_W-1:0] sel_addr;
   logic                   addr_ok;
   logic                   data_eq;
   logic                   data_ok;
   logic                   dir_ok;

   // ==========================================================================
   // Match evaluation
   always_comb begin
      sel_valid = ctl.instruction_select ? bus.fetch_valid : bus.access_valid;
      sel_addr  = ctl.instruction_select ? bus.pc : bus.addr;
      if (range_mode) begin
         addr_ok = (sel_addr >= cmp_addr) && (sel_addr <= range_hi);
      end else begin
         addr_ok = (sel_addr == cmp_addr);
      end
      data_eq = (((bus.data ^ data_val) & data_mask) == '0);
      data_ok = !use_data || ctl.instruction_select || (data_eq ^ ctl.data_mismatch_select);
      dir_ok  = ctl.instruction_select || !ctl.direction_qualify_enable || (bus.rw == ctl.rw);
      hit     = ctl.en && sel_valid && addr_ok && data_ok && dir_ok;
   end

endmodule

// [hw/dbc_top.sv]
// Notes on behaviour
// - Writes to comparator registers are dropped while armed or profiling; reads always work.
// - Outside range mode, each address bit gives the level the matching bus address bit must carry.
// - Comparator A data bits give expected data levels where the mask bit is one.
// - Mask zero excludes a data bit; mask one requires equality.
// - Data value is byte accessible, lowest address holds bits 31 to 24.
// - Data mask is byte accessible, most significant byte first.
// - Instruction select zero compares data addresses, one compares the program counter.
// - Direction bit ignored unless qualify enabled; both ignored with instruction select.
// - With qualify enabled, bus direction must equal the direction bit.
// - A comparator matches only while its enable bit is one.
// - In range mode A's control qualifies the range and B's control is ignored.
// - Comparator A data value resets to zero.
// - A's inversion bit matches on masked data difference; ignored with instruction select.
// - Profiling flag sets on first profiling entry, clears when transmission ends.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dbc_consts.svh"

module dbc_top
   import dbc_pkg::*;
(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [`DBC_AXI_AW-1:0]    s_axi_awaddr,
   input  wire logic [2:0]                s_axi_awprot,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [`DBC_AXI_AW-1:0]    s_axi_araddr,
   input  wire logic [2:0]                s_axi_arprot,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire dbc_core_bus_t             core_bus,
   input  wire logic                      debug_armed,
   input  wire logic                      profile_first_entry,
   input  wire logic                      profile_end,
   output logic                           match_a,
   output logic                           match_b,
   output logic                           profiling_active
);

   // ==========================================================================
   // Helper functions
   function automatic logic [`DBC_IDX_W-1:0] idx_of(input logic [`DBC_AXI_AW-1:0] addr);
      idx_of = addr[`DBC_AXI_AW-1:`DBC_IDX_LSB];
   endfunction

   function automatic logic is_mapped(input logic [`DBC_IDX_W-1:0] idx);
      is_mapped = (idx == `DBC_IDX_A_CTL)
               || (idx >= `DBC_IDX_A_ADDR_H && idx <= `DBC_IDX_B_CTL)
               || (idx >= `DBC_IDX_B_ADDR_H && idx <= `DBC_IDX_B_ADDR_L)
               || (idx == `DBC_IDX_CONFIG) || (idx == `DBC_IDX_STATUS);
   endfunction

   function automatic dbc_ctl_t ctl_of(input logic [7:0] b);
      ctl_of.data_mismatch_select  = b[`DBC_CTL_NDB];
      ctl_of.instruction_select = b[`DBC_CTL_INSTRUCTION_SELECT];
      ctl_of.rw   = b[`DBC_CTL_RW];
      ctl_of.direction_qualify_enable  = b[`DBC_CTL_RWE];
      ctl_of.en   = b[`DBC_CTL_EN];
   endfunction

   // ==========================================================================
   // Registers
   logic [7:0]              a_ctl_q;
   logic [`DBC_ADDR_W-1:0]  a_addr_q;
   logic [`DBC_DATA_W-1:0]  a_data_q;
   logic [`DBC_DATA_W-1:0]  a_mask_q;
   logic [7:0]              b_ctl_q;
   logic [`DBC_ADDR_W-1:0]  b_addr_q;
   logic                    range_mode_q;
   logic                    prof_q;
   logic                    match_a_q;
   logic                    match_b_q;

   // ==========================================================================
   // AXI write channel state
   logic                    awready_q;
   logic                    wready_q;
   logic                    aw_held_q;
   logic                    w_held_q;
   logic [`DBC_IDX_W-1:0]   aw_idx_q;
   logic [7:0]              w_byte_q;
   logic                    w_strb_q;
   logic                    bvalid_q;
   logic [1:0]              bresp_q;
   logic                    do_write;
   logic                    wr_lock;
   logic                    wr_en;

   // ==========================================================================
   // AXI read channel state
   logic                    arready_q;
   logic                    rvalid_q;
   logic [31:0]             rdata_q;
   logic [1:0]              rresp_q;
   logic [`DBC_IDX_W-1:0]   ar_idx;
   logic [7:0]              rd_byte;

   // ==========================================================================
   // Match logic
   logic                    hit_a;
   logic                    hit_b;
   dbc_ctl_t                ctl_a;
   dbc_ctl_t                ctl_b;

   assign ctl_a = ctl_of(a_ctl_q);
   assign ctl_b = ctl_of(b_ctl_q & `DBC_CTL_B_MASK);

   dbc_match u_match_a (
      .ctl        (ctl_a),
      .cmp_addr   (a_addr_q),
      .data_val   (a_data_q),
      .data_mask  (a_mask_q),
      .use_data   (1'b1),
      .range_mode (range_mode_q),
      .range_hi   (b_addr_q),
      .bus        (core_bus),
      .hit        (hit_a)
   );

   dbc_match u_match_b (
      .ctl        (ctl_b),
      .cmp_addr   (b_addr_q),
      .data_val   (a_data_q),
      .data_mask  (a_mask_q),
      .use_data   (1'b0),
      .range_mode (1'b0),
      .range_hi   (b_addr_q),
      .bus        (core_bus),
      .hit        (hit_b)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_a_q <= 1'b0;
         match_b_q <= 1'b0;
      end else begin
         match_a_q <= hit_a;
         match_b_q <= hit_b && !range_mode_q;
      end
   end

   // ==========================================================================
   // Profiling flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prof_q <= 1'b0;
      end else if (profile_first_entry) begin
         prof_q <= 1'b1;
      end else if (profile_end) begin
         prof_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Write address and data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         aw_held_q <= 1'b0;
         aw_idx_q  <= '0;
      end else if (s_axi_awvalid && awready_q) begin
         awready_q <= 1'b0;
         aw_held_q <= 1'b1;
         aw_idx_q  <= idx_of(s_axi_awaddr);
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end else if (!aw_held_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'b1;
         w_held_q <= 1'b0;
         w_byte_q <= 8'h00;
         w_strb_q <= 1'b0;
      end else if (s_axi_wvalid && wready_q) begin
         wready_q <= 1'b0;
         w_held_q <= 1'b1;
         w_byte_q <= s_axi_wdata[7:0];
         w_strb_q <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end else if (!w_held_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign wr_lock  = debug_armed || prof_q;
   assign wr_en    = do_write && w_strb_q && !wr_lock;

   // ==========================================================================
   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `DBC_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= is_mapped(aw_idx_q) ? `DBC_RESP_OKAY : `DBC_RESP_SLVERR;
      end else if (s_axi_bready && bvalid_q) begin
         bvalid_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_ctl_q      <= `DBC_RST_CTL;
         b_ctl_q      <= `DBC_RST_CTL;
         range_mode_q <= `DBC_RST_CFG;
      end else if (wr_en) begin
         case (aw_idx_q)
            `DBC_IDX_A_CTL:  a_ctl_q      <= w_byte_q & `DBC_CTL_A_MASK;
            `DBC_IDX_B_CTL:  b_ctl_q      <= w_byte_q & `DBC_CTL_B_MASK;
            `DBC_IDX_CONFIG: range_mode_q <= w_byte_q[`DBC_CFG_RANGE];
            default: begin
            end
         endcase
      end
   end

   // ==========================================================================
   // Address registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_addr_q <= `DBC_RST_ADDR;
         b_addr_q <= `DBC_RST_ADDR;
      end else if (wr_en) begin
         case (aw_idx_q)
            `DBC_IDX_A_ADDR_H: a_addr_q[23:16] <= w_byte_q;
            `DBC_IDX_A_ADDR_M: a_addr_q[15:8]  <= w_byte_q;
            `DBC_IDX_A_ADDR_L: a_addr_q[7:0]   <= w_byte_q;
            `DBC_IDX_B_ADDR_H: b_addr_q[23:16] <= w_byte_q;
            `DBC_IDX_B_ADDR_M: b_addr_q[15:8]  <= w_byte_q;
            `DBC_IDX_B_ADDR_L: b_addr_q[7:0]   <= w_byte_q;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================================
   // Data value and mask registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_data_q <= `DBC_RST_DATA;
         a_mask_q <= `DBC_RST_MASK;
      end else if (wr_en) begin
         for (int i = 0; i < `DBC_BYTES_PER_WORD; i++) begin
            if (aw_idx_q == `DBC_IDX_A_DATA0 + i[`DBC_IDX_W-1:0]) begin
               a_data_q[31 - 8 * i -: 8] <= w_byte_q;
            end
            if (aw_idx_q == `DBC_IDX_A_MASK0 + i[`DBC_IDX_W-1:0]) begin
               a_mask_q[31 - 8 * i -: 8] <= w_byte_q;
            end
         end
      end
   end

   // ==========================================================================
   // Read data mux
   assign ar_idx = idx_of(s_axi_araddr);

   always_comb begin
      rd_byte = 8'h00;
      case (ar_idx)
         `DBC_IDX_A_CTL:    rd_byte = a_ctl_q;
         `DBC_IDX_A_ADDR_H: rd_byte = a_addr_q[23:16];
         `DBC_IDX_A_ADDR_M: rd_byte = a_addr_q[15:8];
         `DBC_IDX_A_ADDR_L: rd_byte = a_addr_q[7:0];
         `DBC_IDX_B_CTL:    rd_byte = b_ctl_q & `DBC_CTL_B_MASK;
         `DBC_IDX_B_ADDR_H: rd_byte = b_addr_q[23:16];
         `DBC_IDX_B_ADDR_M: rd_byte = b_addr_q[15:8];
         `DBC_IDX_B_ADDR_L: rd_byte = b_addr_q[7:0];
         `DBC_IDX_CONFIG:   rd_byte[`DBC_CFG_RANGE] = range_mode_q;
         `DBC_IDX_STATUS: begin
            rd_byte[`DBC_STS_ARMED]   = debug_armed;
            rd_byte[`DBC_STS_PROF]    = prof_q;
            rd_byte[`DBC_STS_MATCH_A] = match_a_q;
            rd_byte[`DBC_STS_MATCH_B] = match_b_q;
         end
         default: begin
            for (int i = 0; i < `DBC_BYTES_PER_WORD; i++) begin
               if (ar_idx == `DBC_IDX_A_DATA0 + i[`DBC_IDX_W-1:0]) begin
                  rd_byte = a_data_q[31 - 8 * i -: 8];
               end
               if (ar_idx == `DBC_IDX_A_MASK0 + i[`DBC_IDX_W-1:0]) begin
                  rd_byte = a_mask_q[31 - 8 * i -: 8];
               end
            end
         end
      endcase
   end

   // ==========================================================================
   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `DBC_RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= {24'h000000, rd_byte};
         rresp_q   <= is_mapped(ar_idx) ? `DBC_RESP_OKAY : `DBC_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ==========================================================================
   // Outputs
   assign s_axi_awready    = awready_q;
   assign s_axi_wready     = wready_q;
   assign s_axi_bvalid     = bvalid_q;
   assign s_axi_bresp      = bresp_q;
   assign s_axi_arready    = arready_q;
   assign s_axi_rvalid     = rvalid_q;
   assign s_axi_rdata      = rdata_q;
   assign s_axi_rresp      = rresp_q;
   assign match_a          = match_a_q;
   assign match_b          = match_b_q;
   assign profiling_active = prof_q;

endmodule

// [verif/dbc_top_sva.sv]
`timescale 1ns/1ps
// ====================
// Bus, match and profiling flag checks
module dbc_top_sva
   import dbc_pkg::*;
(
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          s_axi_awvalid,
   input wire logic          s_axi_awready,
   input wire logic          s_axi_wvalid,
   input wire logic          s_axi_wready,
   input wire logic [1:0]    s_axi_bresp,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_bready,
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic [31:0]   s_axi_rdata,
   input wire logic          s_axi_rvalid,
   input wire logic          s_axi_rready,
   input wire dbc_core_bus_t core_bus,
   input wire logic          profile_first_entry,
   input wire logic          profile_end,
   input wire logic          match_a,
   input wire logic          match_b,
   input wire logic          profiling_active
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence bus_idle;
      !core_bus.access_valid && !core_bus.fetch_valid;
   endsequence

   a_write_answer: assert property (wr_both |=> ##1 s_axi_bvalid)
      else $error("write response missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_idle_nomatch: assert property (bus_idle |=> !match_a && !match_b)
      else $error("match without bus access");
   a_prof_set: assert property (profile_first_entry |=> profiling_active)
      else $error("profiling flag not set");
   a_prof_clear: assert property (profile_end && !profile_first_entry |=> !profiling_active)
      else $error("profiling flag not cleared");
   a_prof_steady: assert property (!profile_end && !profile_first_entry |=> $stable(profiling_active))
      else $error("profiling flag changed alone");
endmodule

bind dbc_top dbc_top_sva i_dbc_top_sva (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .core_bus(core_bus), .profile_first_entry(profile_first_entry),
   .profile_end(profile_end), .match_a(match_a), .match_b(match_b), .profiling_active(profiling_active));

// [verif/dbc_core_model.sv]
`timescale 1ns/1ps
// ====================
// Core bus model: one access per call
module dbc_core_model
   import dbc_pkg::*;
(
   input wire logic aclk,
   output dbc_core_bus_t bus
);
   initial bus = '0;

   // Idle cycle shows inverted payload, not the last one
   task automatic pulse(input dbc_core_bus_t b);
      @(posedge aclk);
      bus <= b;
      @(posedge aclk);
      bus <= '{1'b0, ~b.rw, ~b.addr, ~b.data, 1'b0, ~b.pc};
   endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
`include "dbc_consts.svh"
module testbench
   import dbc_pkg::*;
;
   typedef struct packed {logic [7:0] ctl; logic av, rw, fv, aok, dok, ex;} dbc_row_t;
   localparam logic [23:0] A_ADR = 24'h123456;
   localparam logic [31:0] GOOD  = 32'h11AA33BB;
   localparam logic [31:0] BAD   = 32'h12223344;
   logic          aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic          arvalid = 0, rready = 0, armed = 0, pfe = 0, pend = 0;
   logic [11:0]   awaddr = 0, araddr = 0;
   logic [31:0]   wdata = 0;
   wire logic     awready, wready, bvalid, arready, rvalid, match_a, match_b, prof;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   dbc_core_bus_t bus;
   int            err_count = 0, n_compared = 0;
   logic [9:0]    si [14] = '{10'h115, 10'h116, 10'h117, 10'h118, 10'h119, 10'h11A, 10'h11B,
                              10'h11C, 10'h11D, 10'h11E, 10'h11F, 10'h125, 10'h126, 10'h127};
   logic [7:0]    sd [14] = '{8'h12, 8'h34, 8'h56, 8'h11, 8'h22, 8'h33, 8'h44,
                              8'hFF, 8'h00, 8'hFF, 8'h00, 8'h12, 8'h34, 8'h60};
   dbc_row_t      rows [13] = '{'{8'h01,1,1,0,1,1,1}, '{8'h00,1,1,0,1,1,0}, '{8'h01,1,1,0,1,0,0},
      '{8'h41,1,1,0,1,0,1}, '{8'h41,1,1,0,1,1,0}, '{8'h0D,1,0,0,1,1,0}, '{8'h0D,1,1,0,1,1,1},
      '{8'h09,1,0,0,1,1,1}, '{8'h05,1,0,0,1,1,1}, '{8'h21,0,0,1,0,0,1}, '{8'h21,1,1,0,1,1,0},
      '{8'h6D,0,0,1,0,0,1}, '{8'h01,1,1,0,0,1,0}};

   always #5 aclk = ~aclk;

   dbc_core_model i_dbc_core_model (.aclk(aclk), .bus(bus));
   dbc_top i_dbc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .core_bus(bus), .debug_armed(armed), .profile_first_entry(pfe),
      .profile_end(pend), .match_a(match_a), .match_b(match_b), .profiling_active(prof));

   // ====================
   // Tasks
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      cmp(bresp, er);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      cmp(rdata, ed);
      cmp(rresp, er);
   endtask

   // One core access, then both match outputs one cycle later
   task automatic chk(input logic av, rw, fv, input logic [23:0] adr, input logic [31:0] dat,
                      input logic ea, eb);
      i_dbc_core_model.pulse('{av, rw, adr, dat, fv, A_ADR});
      #1;
      cmp(match_a, ea);
      cmp(match_b, eb);
      @(posedge aclk);
   endtask

   task automatic wrap_up();
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #50000;
      err_count++;
      wrap_up();
   end

   // ====================
   // Main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) rd(10'(`DBC_IDX_A_DATA0 + i), 0, 0);
      rd(`DBC_IDX_B_CTL, 0, 0);
      wr(`DBC_IDX_B_CTL, 8'hFF, 0);
      rd(`DBC_IDX_B_CTL, 32'h2D, 0);
      foreach (si[i]) wr(si[i], sd[i], 0);
      rd(`DBC_IDX_A_DATA0, 32'h11, 0);
      rd(`DBC_IDX_A_MASK0, 32'hFF, 0);
      foreach (rows[i]) begin
         wr(`DBC_IDX_A_CTL, rows[i].ctl, 0);
         chk(rows[i].av, rows[i].rw, rows[i].fv, rows[i].aok ? A_ADR : A_ADR ^ 24'h1,
             rows[i].dok ? GOOD : BAD, rows[i].ex, 0);
      end
      wr(`DBC_IDX_B_CTL, 8'h01, 0);
      chk(1, 1, 0, 24'h123460, GOOD, 0, 1);
      armed <= 1'b1;
      wr(`DBC_IDX_A_DATA0, 8'h77, 0);
      rd(`DBC_IDX_A_DATA0, 32'h11, 0);
      rd(`DBC_IDX_STATUS, 32'h1, 0);
      armed <= 1'b0;
      @(posedge aclk);
      pfe <= 1'b1;
      @(posedge aclk);
      pfe <= 1'b0;
      wr(`DBC_IDX_A_MASK0, 8'h00, 0);
      rd(`DBC_IDX_A_MASK0, 32'hFF, 0);
      rd(`DBC_IDX_STATUS, 32'h2, 0);
      cmp(prof, 1);
      pend <= 1'b1;
      @(posedge aclk);
      pend <= 1'b0;
      @(posedge aclk);
      #1;
      cmp(prof, 0);
      @(posedge aclk);
      rd(10'h3FF, 0, `DBC_RESP_SLVERR);
      wr(10'h3FF, 8'h01, `DBC_RESP_SLVERR);
      wr(`DBC_IDX_CONFIG, 8'h01, 0);
      chk(1, 1, 0, 24'h123460, GOOD, 1, 0);
      chk(1, 1, 0, 24'h123458, GOOD, 1, 0);
      rd(`DBC_IDX_CONFIG, 32'h1, 0);
      // Reset in mid-run clears registers and the profiling flag
      pfe     <= 1'b1;
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      pfe     <= 1'b0;
      aresetn <= 1'b1;
      rd(`DBC_IDX_A_DATA0, 0, 0);
      rd(`DBC_IDX_B_CTL, 0, 0);
      cmp(prof, 0);
      wrap_up();
   end
endmodule
